/* File: dsp_exec_regs.vh */
// Behaviour
// - Negated product puts minus register product into chosen accumulator; one cycle, no flags.
// - Product subtract from accumulator; optional writeback; overflow and clip flags updated.
// - Register multiply, four signedness variants, 32-bit product to register pair, low first.
// - Literal multiply uses unsigned 5-bit literal with signed or unsigned register.
// - Negate is invert plus one into file, default or dest register; C DC N OV Z.
// - Single push and pop move one word at stack top in one cycle.
// - Double pop loads two consecutive working registers; two cycles; flags kept.
// - Double push stores two consecutive working registers; two cycles; flags kept.
// - Power save picks sleep or idle from literal bit; updates watchdog and sleep flags.
// - Literal repeat runs the next instruction literal plus one times.
// - Register repeat runs the next instruction register bits 13:0 plus one times.
// - Return with literal loads 10-bit literal into register and returns; three or two cycles.
// - Rotate left through carry: old carry to bit zero, top bit to carry.
// - Rotate left without carry: top bit to bit zero; only N and Z change.
// - Rotate right through carry: old carry to top bit, bit zero to carry.
// - One instruction cycle spans two clock periods.
`ifndef DSP_EXEC_REGS_VH
`define DSP_EXEC_REGS_VH
`define A_CMD    8'h00
`define A_LIT    8'h04
`define A_STAT   8'h08
`define A_ISTAT  8'h0C
`define A_ICLR   8'h10
`define A_IEN    8'h14
`define A_ACCAL  8'h18
`define A_ACCAH  8'h1C
`define A_ACCBL  8'h20
`define A_ACCBH  8'h24
`define A_SP     8'h28
`define A_PC     8'h2C
`define A_LAST   8'h2C
`define WIN_W    2'h1
`define WIN_F    2'h2
`define F_OP     4:0
`define F_RA     8:5
`define F_RB     12:9
`define F_RD     16:13
`define F_MODE   18:17
`define F_ACC    19
`define F_AWB    20
`define F_SHORT  21
`define CMD_W    22
`define M_FILE   2'h0
`define M_DEF    2'h1
`define M_REG    2'h2
`define OP_NOP    5'h00
`define OP_MPYN   5'h01
`define OP_MSC    5'h02
`define OP_MULR   5'h03
`define OP_MULL   5'h04
`define OP_NEG    5'h05
`define OP_PUSH   5'h06
`define OP_POP    5'h07
`define OP_PUSHD  5'h08
`define OP_POPD   5'h09
`define OP_PUSHS  5'h0A
`define OP_POPS   5'h0B
`define OP_POWER_SAVING_ENTRY 5'h0C
`define OP_REPL   5'h0D
`define OP_REPW   5'h0E
`define OP_RESET  5'h0F
`define OP_INTERRUPT_RETURN 5'h10
`define OP_RETURN_WITH_LITERAL  5'h11
`define OP_RETURN 5'h12
`define OP_RLC    5'h13
`define OP_ROTATE_LEFT_NO_CARRY   5'h14
`define OP_RRC    5'h15
`define S_C      0
`define S_DC     1
`define S_N      2
`define S_OV     3
`define S_Z      4
`define EV_DONE  0
`define EV_PWR   1
`define EV_SRST  2
`define EV_WDT   3
`define CYC_ONE  2'h1
`define CYC_DBL  2'h2
`define CYC_RET  2'h3
`define CYC_RETS 2'h2
`define W_AWB    4'hD
`define W_DEF    4'h0
`endif

/* File: dsp_exec_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "dsp_exec_regs.vh"
module dsp_exec_unit #(
	parameter STK_AW  = 4,	// Stack index width
	parameter FILE_AW = 4	// File index width, 4 at most
) (
	input  wire        clk_sys,	// 25 MHz clock
	input  wire        sys_rst,	// Sync reset
	input  wire [7:0]  paddr,	// APB address
	input  wire        psel,	// APB select
	input  wire        penable,	// APB enable
	input  wire        pwrite,	// APB write
	input  wire [31:0] pwdata,	// APB write data
	input  wire        wdtPin,	// Watchdog timeout, async
	output wire [31:0] prdata,	// APB read data
	output wire        pready,	// APB ready
	output wire        pslverr,	// APB error
	output wire        irq		// Interrupt level
);
	localparam ST_IDLE = 3'b001;
	localparam ST_RUN  = 3'b010;
	localparam ST_SLP  = 3'b100;
	localparam [STK_AW-1:0] SP_ONE = 1;
	localparam [STK_AW-1:0] SP_TWO = 2;

	reg [15:0]        default_working_register_q [0:15];
	reg [15:0]        fileReg_q [0:(1<<FILE_AW)-1];
	reg [15:0]        stk_q [0:(1<<STK_AW)-1];
	reg [15:0]        shW_q [0:3];
	reg [4:0]         shF_q;
	reg [39:0]        accA_q;
	reg [39:0]        accB_q;
	reg [4:0]         flg_q;
	reg [3:0]         dspF_q;
	reg [`CMD_W-1:0]  cmd_q;
	reg [13:0]        lit_q;
	reg [13:0]        repPend_q;
	reg [13:0]        iter_q;
	reg [1:0]         cyc_q;
	reg               phase_q;
	reg [2:0]         st_q;
	reg               pwrIdle_q;
	reg               watchdog_timeout_flag_q;
	reg [STK_AW-1:0]  sp_q;
	reg [15:0]        pc_q;
	reg [3:0]         ist_q;
	reg [3:0]         ien_q;
	reg               irq_q;
	reg [31:0]        prdata_q;
	reg               pready_q;
	reg               pslverr_q;
	reg               wdtS1_q;
	reg               wdtS2_q;
	reg               wdtS3_q;
	integer           i;

	wire [4:0]         op     = cmd_q[`F_OP];
	wire [3:0]         rA     = cmd_q[`F_RA];
	wire [3:0]         rB     = cmd_q[`F_RB];
	wire [3:0]         rD     = cmd_q[`F_RD];
	wire [1:0]         mode   = cmd_q[`F_MODE];
	wire [3:0]         rA1    = rA + 4'h1;
	wire [3:0]         rD1    = rD + 4'h1;
	wire [FILE_AW-1:0] fIdx   = rA[FILE_AW-1:0];
	wire [15:0]        wA     = default_working_register_q[rA];
	wire [15:0]        wB     = default_working_register_q[rB];
	wire [15:0]        fA     = fileReg_q[fIdx];
	wire [15:0]        src    = (mode == `M_REG) ? wA : fA;
	wire [STK_AW-1:0]  spM1   = sp_q - SP_ONE;
	wire [STK_AW-1:0]  spM2   = sp_q - SP_TWO;
	wire [STK_AW-1:0]  spP1   = sp_q + SP_ONE;
	wire [15:0]        stkTop = stk_q[spM1];
	wire [15:0]        stkNx  = stk_q[spM2];
	wire               busy   = st_q[1];
	wire               apbWr  = psel & penable & pready_q & pwrite;
	wire               dataWr = apbWr & ~busy;
	wire               cmdGo  = dataWr & (paddr == `A_CMD);
	wire               fin    = busy & phase_q & (cyc_q == 2'h0);
	wire               wdtRise = wdtS2_q & ~wdtS3_q;

	reg               sgnA;
	reg               sgnB;
	reg [15:0]        opB;
	reg [15:0]        uRes;
	reg               nC;
	reg [3:0]         ev;
	reg [3:0]         ist_d;
	reg [3:0]         ien_d;
	reg [31:0]        rdMux;

	wire signed [16:0] mA = {sgnA & wA[15], wA};
	wire signed [16:0] mB = {sgnB & opB[15], opB};
	wire signed [33:0] mP = mA * mB;
	wire [31:0]        prod = mP[31:0];
	wire [39:0]        prod40 = {{8{prod[31]}}, prod};
	wire [39:0]        accCur = cmd_q[`F_ACC] ? accB_q : accA_q;
	wire [39:0]        accOth = cmd_q[`F_ACC] ? accA_q : accB_q;
	wire [39:0]        accNeg = 40'h00_0000_0000 - prod40;
	wire [40:0]        mscDif = {accCur[39], accCur} - {prod40[39], prod40};
	wire [39:0]        accMsc = mscDif[39:0];
	wire               satMsc = mscDif[40] ^ mscDif[39];
	wire               ovMsc  = ~((&accMsc[39:31]) | ~(|accMsc[39:31]));
	wire [15:0]        negRes = ~src + 16'h0001;
	wire [14:0]        stat = {watchdog_timeout_flag_q, st_q[2] & pwrIdle_q, st_q[2] & ~pwrIdle_q,
		busy, dspF_q[2] | dspF_q[3], dspF_q[3], dspF_q[2],
		dspF_q[0] | dspF_q[1], dspF_q[1], dspF_q[0], flg_q};

	assign prdata  = prdata_q;
	assign pready  = pready_q;
	assign pslverr = pslverr_q;
	assign irq     = irq_q;

	function [1:0] opCycles;
		input [4:0] o;
		input       shortRet;
		begin
			case (o)
			`OP_PUSHD, `OP_POPD: opCycles = `CYC_DBL;
			`OP_INTERRUPT_RETURN, `OP_RETURN_WITH_LITERAL, `OP_RETURN:
				opCycles = shortRet ? `CYC_RETS : `CYC_RET;
			default: opCycles = `CYC_ONE;
			endcase
		end
	endfunction

	function mapped;
		input [7:0] a;
		begin
			mapped = ((a <= `A_LAST) && (a[1:0] == 2'h0)) ||
				(a[7:6] == `WIN_W) || (a[7:6] == `WIN_F);
		end
	endfunction

	// Core state cleared by both reset sources
	task coreClear;
		begin
			for (i = 0; i < 16; i = i + 1)
				default_working_register_q[i] <= 16'h0000;
			for (i = 0; i < (1<<FILE_AW); i = i + 1)
				fileReg_q[i] <= 16'h0000;
			for (i = 0; i < (1<<STK_AW); i = i + 1)
				stk_q[i] <= 16'h0000;
			for (i = 0; i < 4; i = i + 1)
				shW_q[i] <= 16'h0000;
			shF_q     <= 5'h00;
			accA_q    <= 40'h00_0000_0000;
			accB_q    <= 40'h00_0000_0000;
			flg_q     <= 5'h00;
			dspF_q    <= 4'h0;
			lit_q     <= 14'h0000;
			repPend_q <= 14'h0000;
			sp_q      <= {STK_AW{1'b0}};
			pc_q      <= 16'h0000;
			pwrIdle_q <= 1'b0;
		end
	endtask

	always @* begin
		sgnA = 1'b1;
		sgnB = 1'b1;
		opB  = wB;
		if (op == `OP_MULR) begin
			sgnA = mode[1];
			sgnB = mode[0];
		end
		if (op == `OP_MULL) begin
			sgnA = mode[1];
			sgnB = 1'b0;
			opB  = {11'h000, lit_q[4:0]};
		end
	end

	always @* begin
		uRes = negRes;
		nC   = ~|src;
		case (op)
		`OP_RLC: begin
			uRes = {src[14:0], flg_q[`S_C]};
			nC   = src[15];
		end
		`OP_ROTATE_LEFT_NO_CARRY: begin
			uRes = {src[14:0], src[15]};
			nC   = flg_q[`S_C];
		end
		`OP_RRC: begin
			uRes = {flg_q[`S_C], src[15:1]};
			nC   = src[0];
		end
		default: ;
		endcase
	end

	// Set beats clear so no event is lost
	always @* begin
		ev = 4'h0;
		ev[`EV_DONE] = fin & (iter_q == 14'h0000);
		ev[`EV_PWR]  = fin & (op == `OP_POWER_SAVING_ENTRY);
		ev[`EV_SRST] = fin & (op == `OP_RESET);
		ev[`EV_WDT]  = wdtRise;
		ist_d = ist_q;
		if (apbWr && paddr == `A_ICLR)
			ist_d = ist_d & ~pwdata[3:0];
		ist_d = ist_d | ev;
		ien_d = (apbWr && paddr == `A_IEN) ? pwdata[3:0] : ien_q;
	end

	always @* begin
		rdMux = 32'h0000_0000;
		case (paddr)
		`A_CMD:   rdMux = {10'h000, cmd_q};
		`A_LIT:   rdMux = {18'h0_0000, lit_q};
		`A_STAT:  rdMux = {17'h0_0000, stat};
		`A_ISTAT: rdMux = {28'h000_0000, ist_q};
		`A_IEN:   rdMux = {28'h000_0000, ien_q};
		`A_ACCAL: rdMux = accA_q[31:0];
		`A_ACCAH: rdMux = {24'h00_0000, accA_q[39:32]};
		`A_ACCBL: rdMux = accB_q[31:0];
		`A_ACCBH: rdMux = {24'h00_0000, accB_q[39:32]};
		`A_SP:    rdMux = {{(32-STK_AW){1'b0}}, sp_q};
		`A_PC:    rdMux = {16'h0000, pc_q};
		default: begin
			if (paddr[7:6] == `WIN_W)
				rdMux = {16'h0000, default_working_register_q[paddr[5:2]]};
			if (paddr[7:6] == `WIN_F)
				rdMux = {16'h0000, fileReg_q[paddr[FILE_AW+1:2]]};
		end
		endcase
	end

	always @(posedge clk_sys) begin
		if (sys_rst) begin
			coreClear;
			cmd_q     <= {`CMD_W{1'b0}};
			iter_q    <= 14'h0000;
			cyc_q     <= 2'h0;
			phase_q   <= 1'b0;
			st_q      <= ST_IDLE;
			watchdog_timeout_flag_q    <= 1'b0;
			ist_q     <= 4'h0;
			ien_q     <= 4'h0;
			irq_q     <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			wdtS1_q   <= 1'b0;
			wdtS2_q   <= 1'b0;
			wdtS3_q   <= 1'b0;
		end else begin
			phase_q   <= ~phase_q;
			wdtS1_q   <= wdtPin;
			wdtS2_q   <= wdtS1_q;
			wdtS3_q   <= wdtS2_q;
			pready_q  <= psel & ~penable & ~pready_q;
			pslverr_q <= psel & ~penable & ~pready_q & ~mapped(paddr);
			if (psel & ~penable)
				prdata_q <= rdMux;
			ist_q <= ist_d;
			ien_q <= ien_d;
			irq_q <= |(ist_d & ien_d);
			if (wdtRise)
				watchdog_timeout_flag_q <= 1'b1;
			if (dataWr && paddr == `A_LIT)
				lit_q <= pwdata[13:0];
			if (dataWr && paddr[7:6] == `WIN_W)
				default_working_register_q[paddr[5:2]] <= pwdata[15:0];
			if (dataWr && paddr[7:6] == `WIN_F)
				fileReg_q[paddr[FILE_AW+1:2]] <= pwdata[15:0];
			case (st_q)
			ST_IDLE, ST_SLP: begin
				if (st_q[2] && wdtRise)
					st_q <= ST_IDLE;
				// Commands are taken on any clock, whatever the phase
				if (cmdGo) begin
					st_q      <= ST_RUN;
					cmd_q     <= pwdata[`CMD_W-1:0];
					cyc_q     <= opCycles(pwdata[`F_OP], pwdata[`F_SHORT]) - 2'h1;
					iter_q    <= repPend_q;
					repPend_q <= 14'h0000;
				end
			end
			ST_RUN: begin
				if (phase_q && cyc_q != 2'h0)
					cyc_q <= cyc_q - 2'h1;
				if (fin) begin
					if (iter_q != 14'h0000) begin
						iter_q <= iter_q - 14'h0001;
						cyc_q  <= opCycles(op, cmd_q[`F_SHORT]) - 2'h1;
					end else begin
						st_q <= (op == `OP_POWER_SAVING_ENTRY) ? ST_SLP : ST_IDLE;
					end
					case (op)
					`OP_MPYN: begin
						if (cmd_q[`F_ACC])
							accB_q <= accNeg;
						else
							accA_q <= accNeg;
					end
					`OP_MSC: begin
						if (cmd_q[`F_ACC]) begin
							accB_q    <= accMsc;
							dspF_q[1] <= ovMsc;
							dspF_q[3] <= dspF_q[3] | satMsc;
						end else begin
							accA_q    <= accMsc;
							dspF_q[0] <= ovMsc;
							dspF_q[2] <= dspF_q[2] | satMsc;
						end
						if (cmd_q[`F_AWB])
							default_working_register_q[`W_AWB] <= accOth[31:16];
					end
					`OP_MULR, `OP_MULL: begin
						default_working_register_q[rD]  <= prod[15:0];
						default_working_register_q[rD1] <= prod[31:16];
					end
					`OP_NEG, `OP_RLC, `OP_ROTATE_LEFT_NO_CARRY, `OP_RRC: begin
						if (mode == `M_REG)
							default_working_register_q[rD] <= uRes;
						else if (mode == `M_DEF)
							default_working_register_q[`W_DEF] <= uRes;
						else
							fileReg_q[fIdx] <= uRes;
						flg_q[`S_N] <= uRes[15];
						flg_q[`S_Z] <= ~|uRes;
						if (op != `OP_ROTATE_LEFT_NO_CARRY)
							flg_q[`S_C] <= nC;
						if (op == `OP_NEG) begin
							flg_q[`S_DC] <= ~|src[3:0];
							flg_q[`S_OV] <= (src == 16'h8000);
						end
					end
					`OP_PUSH: begin
						stk_q[sp_q] <= mode[0] ? wA : fA;
						sp_q        <= spP1;
					end
					`OP_POP: begin
						if (mode[0])
							default_working_register_q[rD] <= stkTop;
						else
							fileReg_q[fIdx] <= stkTop;
						sp_q <= spM1;
					end
					`OP_PUSHD: begin
						stk_q[sp_q] <= wA;
						stk_q[spP1] <= default_working_register_q[rA1];
						sp_q        <= sp_q + SP_TWO;
					end
					`OP_POPD: begin
						default_working_register_q[rD1] <= stkTop;
						default_working_register_q[rD]  <= stkNx;
						sp_q        <= spM2;
					end
					`OP_PUSHS: begin
						for (i = 0; i < 4; i = i + 1)
							shW_q[i] <= default_working_register_q[i];
						shF_q <= flg_q;
					end
					`OP_POPS: begin
						for (i = 0; i < 4; i = i + 1)
							default_working_register_q[i] <= shW_q[i];
						flg_q <= shF_q;
					end
					`OP_POWER_SAVING_ENTRY: begin
						pwrIdle_q <= lit_q[0];
						watchdog_timeout_flag_q    <= 1'b0;
					end
					`OP_REPL: repPend_q <= lit_q;
					`OP_REPW: repPend_q <= wA[13:0];
					`OP_RESET: begin
						coreClear;
						iter_q <= 14'h0000;
						st_q   <= ST_IDLE;
					end
					`OP_INTERRUPT_RETURN: begin
						pc_q  <= stkTop;
						flg_q <= stkNx[4:0];
						sp_q  <= spM2;
					end
					`OP_RETURN_WITH_LITERAL: begin
						default_working_register_q[rD] <= {6'h00, lit_q[9:0]};
						pc_q       <= stkTop;
						sp_q       <= spM1;
					end
					`OP_RETURN: begin
						pc_q <= stkTop;
						sp_q <= spM1;
					end
					default: ;
					endcase
				end
			end
			default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // dsp_exec_unit
`default_nettype wire

/* File: dsp_exec_unit_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsp_exec_regs.vh"
module dsp_exec_properties #(
	parameter STK_AW  = 4,	// Stack index width
	parameter FILE_AW = 4	// File index width
) (
	input wire logic        clk_sys,	// Clock
	input wire logic        sys_rst,	// Sync reset
	input wire logic [7:0]  paddr,	// Address
	input wire logic        psel,	// Select
	input wire logic        penable,	// Enable
	input wire logic        pwrite,	// Write
	input wire logic [31:0] pwdata,	// Write data
	input wire logic        wdtPin,	// Watchdog in
	input wire logic [31:0] prdata,	// Read data
	input wire logic        pready,	// Ready
	input wire logic        pslverr,	// Error
	input wire logic        irq	// Interrupt
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (sys_rst);
	logic       xfer;
	logic       mapped;
	logic       irqWrite;
	logic [3:0] enableMirror_q;
	assign xfer = psel && penable && pready;
	assign mapped = paddr <= `A_LAST || (paddr >= 8'h40 && paddr < 8'hC0);
	assign irqWrite = xfer && pwrite && (paddr == `A_ICLR || paddr == `A_IEN);
	// Enables mirrored from the bus, so masking is judged without a read
	always @(posedge clk_sys) begin
		if (sys_rst)
			enableMirror_q <= 4'h0;
		else if (xfer && pwrite && paddr == `A_IEN)
			enableMirror_q <= pwdata[3:0];
	end
	property p_ready_slot;
		psel && penable && $past(psel && !penable) |-> pready;
	endproperty
	a_ready_slot: assert property (p_ready_slot) else $error("no ready in access");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
	property p_err_ready;
		pslverr |-> pready;
	endproperty
	a_err_ready: assert property (p_err_ready) else $error("error without ready");
	property p_err_unmapped;
		pready && !mapped && paddr[1:0] == 2'h0 |-> pslverr;
	endproperty
	a_err_unmapped: assert property (p_err_unmapped) else $error("unmapped not refused");
	property p_reset_quiet;
		$fell(sys_rst) |-> !pready && !pslverr && !irq;
	endproperty
	a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
	property p_iclr_zero;
		pready && !pwrite && paddr == `A_ICLR |-> prdata == 32'h0000_0000;
	endproperty
	a_iclr_zero: assert property (p_iclr_zero) else $error("clear register read nonzero");
	property p_irq_masked;
		$past(enableMirror_q) == 4'h0 && enableMirror_q == 4'h0 |-> !irq;
	endproperty
	a_irq_masked: assert property (p_irq_masked) else $error("irq while all masked");
	property p_irq_fall;
		$fell(irq) && !$past(sys_rst) |-> $past(irqWrite) || $past(irqWrite, 2);
	endproperty
	a_irq_fall: assert property (p_irq_fall) else $error("irq fell without a write");
endmodule // dsp_exec_properties
`default_nettype wire

/* File: testbench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "dsp_exec_regs.vh"
module testbench;
	logic        clk_sys;
	logic        sys_rst;
	logic [7:0]  paddr;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [31:0] pwdata;
	logic        wdtPin;
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         irq;
	logic [31:0] rd;
	logic        er;
	logic [15:0] w[16];
	logic [15:0] stk[16];
	logic [15:0] sh[4];
	logic [39:0] acc[2];
	logic [15:0] lit;
	logic [15:0] rep;
	logic [4:0]  fl;
	logic [4:0]  shf;
	logic [3:0]  sp;
	int          num_errors;
	int          checks;
	int          cyc = 0;
	int          seed;
	dsp_exec_unit dsp_exec_unit_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .wdtPin(wdtPin),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	task test_done;
		if (num_errors == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			num_errors++;
			test_done();
		end
	end
	task chk(input [31:0] g, input [31:0] e);
		checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task apb(input bit wr, input [7:0] a, input [31:0] d);
		int n;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		n = 0;
		// Look mid-cycle so ready is settled before the taking edge
		@(negedge clk_sys);
		while (pready !== 1'b1 && n < 20) begin
			@(negedge clk_sys);
			n++;
		end
		if (n == 20)
			num_errors++;
		rd = prdata;
		er = pslverr;
		@(posedge clk_sys);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdc(input [7:0] a, input [31:0] e);
		apb(0, a, 0);
		chk(rd, e);
	endtask
	task wrw(input [3:0] i, input [15:0] v);
		w[i] = v;
		apb(1, {2'h1, i, 2'h0}, {16'h0, v});
	endtask
	task setlit(input [15:0] v);
		lit = v;
		apb(1, `A_LIT, {16'h0, v});
	endtask
	task pollst(input int b, input bit v);
		int n;
		n = 0;
		do begin
			apb(0, `A_STAT, 0);
			n++;
		end while (rd[b] !== v && n < 50);
		chk(rd[b], v);
	endtask
	function automatic [21:0] cw(input [4:0] op, input [3:0] a, b, d, input [1:0] m);
		cw = {3'h0, m, d, b, a, op};
	endfunction
	task ex(input [21:0] c);
		logic [3:0]  a;
		logic [3:0]  d;
		logic [31:0] p;
		logic [15:0] s;
		logic [15:0] t;
		logic [15:0] r;
		int          n;
		a = c[`F_RA];
		d = c[`F_RD];
		n = rep;
		rep = 16'h0;
		apb(1, `A_CMD, {10'h0, c});
		for (int k = 0; k <= n; k++) begin
			s = w[a];
			t = (c[`F_OP] == `OP_MULL) ? {11'h0, lit[4:0]} : w[c[`F_RB]];
			p = $signed({c[18] & s[15], s}) * $signed({c[17] & t[15], t});
			case (c[`F_OP])
			`OP_MULR, `OP_MULL: begin
				w[d] = p[15:0];
				w[d + 4'h1] = p[31:16];
			end
			`OP_MPYN: acc[c[19]] = -{{8{p[31]}}, p};
			`OP_MSC: acc[c[19]] = acc[c[19]] - {{8{p[31]}}, p};
			`OP_NEG: begin
				r = ~s + 16'h1;
				fl = {r == 0, s == 16'h8000, r[15], s[3:0] == 0, s == 0};
				w[d] = r;
			end
			`OP_RLC: begin
				r = {s[14:0], fl[0]};
				fl = {r == 0, fl[3], r[15], fl[1], s[15]};
				w[d] = r;
			end
			`OP_ROTATE_LEFT_NO_CARRY: begin
				r = {s[14:0], s[15]};
				fl = {r == 0, fl[3], r[15], fl[1:0]};
				w[d] = r;
			end
			`OP_RRC: begin
				r = {fl[0], s[15:1]};
				fl = {r == 0, fl[3], r[15], fl[1], s[0]};
				w[d] = r;
			end
			`OP_PUSH: stk[sp++] = s;
			`OP_POP: w[d] = stk[--sp];
			`OP_PUSHD: begin
				stk[sp] = s;
				stk[sp + 4'h1] = w[a + 4'h1];
				sp += 4'h2;
			end
			`OP_POPD: begin
				w[d + 4'h1] = stk[sp - 4'h1];
				w[d] = stk[sp - 4'h2];
				sp -= 4'h2;
			end
			`OP_PUSHS: begin
				sh = w[0:3];
				shf = fl;
			end
			`OP_POPS: begin
				w[0:3] = sh;
				fl = shf;
			end
			`OP_RETURN_WITH_LITERAL: begin
				w[d] = {6'h0, lit[9:0]};
				sp--;
			end
			`OP_RETURN: sp--;
			`OP_INTERRUPT_RETURN: begin
				fl = stk[sp - 4'h2][4:0];
				sp -= 4'h2;
			end
			`OP_REPL: rep = {2'h0, lit[13:0]};
			`OP_REPW: rep = s;
			`OP_RESET: begin
				foreach (w[i]) w[i] = 16'h0;
				sp = 4'h0;
				fl = 5'h0;
				acc[0] = 40'h0;
				acc[1] = 40'h0;
			end
			default: ;
			endcase
		end
		pollst(11, 0);
		apb(0, `A_STAT, 0);
		chk(rd[10:0], {6'h0, fl});
		rdc({2'h1, d, 2'h0}, w[d]);
		rdc({2'h1, d + 4'h1, 2'h0}, w[d + 4'h1]);
		rdc(`A_SP, sp);
		rdc(`A_ACCAL, acc[0][31:0]);
		rdc(`A_ACCAH, acc[0][39:32]);
		rdc(`A_ACCBL, acc[1][31:0]);
		rdc(`A_ACCBH, acc[1][39:32]);
	endtask
	initial begin
		seed = 32'h347f_4f96;
		{psel, penable, pwrite, paddr, pwdata, wdtPin} = 0;
		sys_rst = 1'b1;
		{num_errors, checks} = 0;
		{fl, sp, lit, rep} = 0;
		acc[0] = 40'h0;
		acc[1] = 40'h0;
		foreach (stk[i]) stk[i] = 16'h0;
		repeat (10) @(posedge clk_sys);
		sys_rst <= 1'b0;
		rdc(`A_STAT, 0);
		rdc(`A_SP, 0);
		apb(0, 8'h30, 0);
		chk(er, 1);
		apb(1, `A_IEN, 1);
		for (int i = 0; i < 16; i++) wrw(i[3:0], 16'($random(seed)));
		wrw(4'h8, 16'h8000);
		wrw(4'h9, 16'h0000);
		for (int i = 0; i < 4; i++) ex(cw(`OP_MULR, 4'h1, 4'h2, 4'h4, i[1:0]));
		chk(irq, 1);
		apb(1, `A_ICLR, 1);
		rdc(`A_ISTAT, 0);
		chk(irq, 0);
		setlit(16'h001b);
		ex(cw(`OP_MULL, 4'h3, 4'h0, 4'h6, 2'h2));
		ex(cw(`OP_MULL, 4'h3, 4'h0, 4'h6, 2'h0));
		for (int i = 7; i < 10; i++) ex(cw(`OP_NEG, i[3:0], 4'h0, 4'ha, 2'h2));
		for (int i = 0; i < 6; i++)
			ex(cw(5'(`OP_RLC + i / 2), i[0] ? 4'h8 : 4'h1, 4'h0, 4'hb, 2'h2));
		setlit(16'h0002);
		ex(cw(`OP_REPL, 4'h0, 4'h0, 4'h0, 2'h0));
		ex(cw(`OP_ROTATE_LEFT_NO_CARRY, 4'hb, 4'h0, 4'hb, 2'h2));
		wrw(4'hc, 16'h0003);
		ex(cw(`OP_REPW, 4'hc, 4'h0, 4'h0, 2'h0));
		ex(cw(`OP_RRC, 4'hb, 4'h0, 4'hb, 2'h2));
		ex(cw(`OP_PUSH, 4'h1, 4'h0, 4'h0, 2'h1));
		ex(cw(`OP_PUSHD, 4'h2, 4'h0, 4'h0, 2'h0));
		ex(cw(`OP_POPD, 4'h0, 4'h0, 4'hd, 2'h0));
		ex(cw(`OP_POP, 4'h0, 4'h0, 4'hf, 2'h1));
		ex(cw(`OP_MPYN, 4'h1, 4'h2, 4'h0, 2'h3));
		ex(cw(`OP_MSC, 4'h1, 4'h2, 4'h0, 2'h3) | 22'h8_0000);
		ex(cw(`OP_PUSH, 4'h7, 4'h0, 4'h0, 2'h1));
		setlit(16'h02a5);
		ex(cw(`OP_RETURN_WITH_LITERAL, 4'h0, 4'h0, 4'h5, 2'h0) | 22'h20_0000);
		wrw(4'h3, 16'h001f);
		ex(cw(`OP_PUSHD, 4'h3, 4'h0, 4'h0, 2'h0));
		ex(cw(`OP_INTERRUPT_RETURN, 4'h0, 4'h0, 4'h0, 2'h0));
		ex(cw(`OP_PUSH, 4'h6, 4'h0, 4'h0, 2'h1));
		ex(cw(`OP_RETURN, 4'h0, 4'h0, 4'h0, 2'h0) | 22'h20_0000);
		ex(cw(`OP_NOP, 4'h0, 4'h0, 4'h0, 2'h0));
		ex(cw(`OP_PUSHS, 4'h0, 4'h0, 4'h0, 2'h0));
		ex(cw(`OP_NEG, 4'h9, 4'h0, 4'h0, 2'h2));
		ex(cw(`OP_POPS, 4'h0, 4'h0, 4'h0, 2'h0));
		setlit(16'h0000);
		ex(cw(`OP_POWER_SAVING_ENTRY, 4'h0, 4'h0, 4'h0, 2'h0));
		pollst(12, 1);
		wdtPin <= 1'b1;
		pollst(14, 1);
		pollst(12, 0);
		wdtPin <= 1'b0;
		ex(cw(`OP_RESET, 4'h0, 4'h0, 4'h0, 2'h0));
		apb(1, `A_IEN, 0);
		rdc(`A_ISTAT, 32'h0000_000f);
		chk(irq, 0);
		apb(1, `A_ICLR, 32'h0000_000f);
		rdc(`A_ISTAT, 0);
		test_done();
	end
endmodule // testbench
bind dsp_exec_unit dsp_exec_properties #(.STK_AW(STK_AW), .FILE_AW(FILE_AW)) dsp_exec_properties_i (
	.clk_sys(clk_sys), .sys_rst(sys_rst), .paddr(paddr), .psel(psel), .penable(penable),
	.pwrite(pwrite), .pwdata(pwdata), .wdtPin(wdtPin), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .irq(irq));
`default_nettype wire
